// >>> rtl/decu_defs.svh
`ifndef DECU_DEFS_SVH
`define DECU_DEFS_SVH

// Register byte offsets (APB word aligned)
`define DECU_OFS_STATE     12'h000
`define DECU_OFS_PIN       12'h008
`define DECU_OFS_GUARD     12'h00C
`define DECU_OFS_SWB       12'h010
`define DECU_OFS_TRIG0     12'h020
`define DECU_OFS_TRIG1     12'h024
`define DECU_OFS_IRQ       12'h0BC

// State register fields
`define DECU_ON_BIT        0
`define DECU_HALT_BIT      1
`define DECU_HMASK_BIT     2
`define DECU_SNOW_BIT      4
`define DECU_SPRI_BIT      6
`define DECU_ORG_LO        8
`define DECU_ORG_HI        12

// Specifier fields
`define DECU_ACT_HI        2
`define DECU_PCB_BIT       3
`define DECU_STALL_SIGNAL_NOW_BIT      5
`define DECU_SPEC_MASK     32'h0000002F
`define DECU_TRIG_MASK     32'h00000F2F
`define DECU_COMBO_LO      8

// Irq control fields
`define DECU_IRQ_WMASK     32'h00001CFF
`define DECU_PRIO_HI       7
`define DECU_TGT_LO        10
`define DECU_TGT_HI        11
`define DECU_EN_BIT        12
`define DECU_PEND_BIT      13
`define DECU_CLR_BIT       14
`define DECU_SET_BIT       15

// Event origin codes
`define DECU_ORG_PIN       5'h00
`define DECU_ORG_GUARD     5'h01
`define DECU_ORG_SW        5'h02
`define DECU_ORG_TRIG0     5'h10
`define DECU_ORG_TRIG1     5'h11

`define DECU_ZERO32        32'h00000000

`endif

// >>> rtl/decu_pkg.sv
package decu_pkg;
   typedef enum logic [2:0] {
      DECU_ACT_NONE = 3'b000,
      DECU_ACT_PIN  = 3'b001,
      DECU_ACT_HALT = 3'b010,
      DECU_ACT_TRAP = 3'b011,
      DECU_ACT_SWBK = 3'b100
   } decu_action_type;
endpackage

// >>> rtl/decu_event_ctrl.sv
// Behaviour
// - Bit 0 of status shows whether debug was enabled at reset.
// - Halt field bits 2:1; upper is write mask reading zero, lower is halt.
// - Reads give 00 running, 01 halted; writes without mask leave halt.
// - Write 10 clears halt; 11 sets it only when debug is enabled.
// - Bit 4 shows current suspend signal state.
// - Bit 6 shows previous suspend signal state, read only.
// - Bits 12:8 hold source of last halt or trap: 0 pin, 1 guard, 2 sw, 16+n trigger.
// - Action code: none, pulse break pin, halt, trap, software breakpoint.
// - Action codes 101 to 111 behave like none.
// - Bit 3 selects break before make when set, after when clear.
// - On an event with an action other than none the suspend output takes the specifier's bit 5.
// - Trigger bits 8 to 11 each enable one data/code pairing.
// - Reserved bits read as zero.
// - Bits 7:0 priority; zero never serviced, FF highest.
// - Bits 11:10 route request: 00 CPU, 01 coprocessor, 1x reserved.
// - Bit 12 enables the software breakpoint request.
// - Bit 13 reads 1 while a request is pending.
// - Writing bit 14 clears pending; not stored; no action with set.
// - Writing bit 15 sets pending; not stored; no action with clear.
// - Halt entry or trap updates origin and pulses break pin one cycle.
// - Events involving data triggers are always break after make.
// - Halt does not mask the request; irqRequest is still driven while halted.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "decu_defs.svh"

module decu_event_ctrl
   import decu_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Debug strap and event sources
   input  wire logic        dbgEnableStrap,
   input  wire logic        breakInEvent,
   input  wire logic        guardAccessEvent,
   input  wire logic        swDebugEvent,
   input  wire logic [3:0]  trig0Combo,
   input  wire logic [3:0]  trig1Combo,
   // Outputs to core and pins
   output var  logic        breakOutPin,
   output var  logic        haltOut,
   output var  logic        suspendOut,
   output var  logic        breakBeforeMake,
   output var  logic        eventTaken,
   output var  logic [2:0]  eventActionOut,
   output var  logic        irqRequest,
   output var  logic [7:0]  irqPriorityOut,
   output var  logic        irqToCoproc
);

   ////////////////////////////////////////////////////////////////////
   logic        dbgOn_reg;
   logic        strapTaken_reg;
   logic        halt_reg;
   logic        suspPrior_reg;
   logic [4:0]  origin_reg;
   logic [31:0] spec_reg [0:4];
   logic [7:0]  irqPrio_reg;
   logic [1:0]  irqTarget_reg;
   logic        irqEnable_reg;
   logic        irqPend_reg;

   logic        wrEn;
   logic        rdEn;
   logic        hitState, hitPin, hitGuard, hitSw, hitT0, hitT1, hitIrq;
   logic [4:0]  fire;
   logic        anyFire;
   logic [2:0]  winIdx;
   logic [31:0] winSpec;
   logic [2:0]  winAct;
   logic [4:0]  winOrigin;
   logic        winIsTrig;
   logic [31:0] rdData_next;

   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && !penable && !pwrite;

   assign hitState = (paddr == `DECU_OFS_STATE);
   assign hitPin   = (paddr == `DECU_OFS_PIN);
   assign hitGuard = (paddr == `DECU_OFS_GUARD);
   assign hitSw    = (paddr == `DECU_OFS_SWB);
   assign hitT0    = (paddr == `DECU_OFS_TRIG0);
   assign hitT1    = (paddr == `DECU_OFS_TRIG1);
   assign hitIrq   = (paddr == `DECU_OFS_IRQ);

   ////////////////////////////////////////////////////////////////////
   // Event detection; triggers fire only through enabled pairings
   assign fire[0] = breakInEvent;
   assign fire[1] = guardAccessEvent;
   assign fire[2] = swDebugEvent && dbgOn_reg;
   assign fire[3] = |(trig0Combo & spec_reg[3][`DECU_COMBO_LO +: 4]);
   assign fire[4] = |(trig1Combo & spec_reg[4][`DECU_COMBO_LO +: 4]);
   assign anyFire = |fire;

   // Fixed priority: pin, guard, software, trigger 0, trigger 1
   always_comb begin
      winIdx    = 3'd0;
      winOrigin = `DECU_ORG_PIN;
      if (fire[0]) begin
         winIdx    = 3'd0;
         winOrigin = `DECU_ORG_PIN;
      end else if (fire[1]) begin
         winIdx    = 3'd1;
         winOrigin = `DECU_ORG_GUARD;
      end else if (fire[2]) begin
         winIdx    = 3'd2;
         winOrigin = `DECU_ORG_SW;
      end else if (fire[3]) begin
         winIdx    = 3'd3;
         winOrigin = `DECU_ORG_TRIG0;
      end else if (fire[4]) begin
         winIdx    = 3'd4;
         winOrigin = `DECU_ORG_TRIG1;
      end
   end

   assign winSpec   = spec_reg[winIdx];
   assign winIsTrig = (winIdx == 3'd3) || (winIdx == 3'd4);

   // Reserved action codes fold into none
   always_comb begin
      unique case (winSpec[`DECU_ACT_HI:0])
         DECU_ACT_PIN:  winAct = DECU_ACT_PIN;
         DECU_ACT_HALT: winAct = DECU_ACT_HALT;
         DECU_ACT_TRAP: winAct = DECU_ACT_TRAP;
         DECU_ACT_SWBK: winAct = DECU_ACT_SWBK;
         default:       winAct = DECU_ACT_NONE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Strap caught at first clock after reset release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dbgOn_reg      <= 1'b0;
         strapTaken_reg <= 1'b0;
      end else if (!strapTaken_reg) begin
         dbgOn_reg      <= dbgEnableStrap;
         strapTaken_reg <= 1'b1;
      end
   end

   // Halt bit: hardware entry wins over software clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         halt_reg <= 1'b0;
      end else if (anyFire && winAct == DECU_ACT_HALT) begin
         halt_reg <= 1'b1;
      end else if (wrEn && hitState && pwdata[`DECU_HMASK_BIT]) begin
         if (!pwdata[`DECU_HALT_BIT]) begin
            halt_reg <= 1'b0;
         end else if (dbgOn_reg) begin
            halt_reg <= 1'b1;
         end
      end
   end

   // Suspend: event drives it, software may also write it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         suspendOut    <= 1'b0;
         suspPrior_reg <= 1'b0;
      end else if (anyFire && winAct != DECU_ACT_NONE) begin
         suspendOut    <= winSpec[`DECU_STALL_SIGNAL_NOW_BIT];
         suspPrior_reg <= suspendOut;
      end else if (wrEn && hitState) begin
         suspendOut    <= pwdata[`DECU_SNOW_BIT];
         suspPrior_reg <= suspendOut;
      end
   end

   // Origin recorded only for halt and trap entries
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         origin_reg  <= 5'h00;
         breakOutPin <= 1'b0;
      end else begin
         breakOutPin <= anyFire && (winAct == DECU_ACT_PIN || winAct == DECU_ACT_HALT
                        || winAct == DECU_ACT_TRAP);
         if (anyFire && (winAct == DECU_ACT_HALT || winAct == DECU_ACT_TRAP)) begin
            origin_reg <= winOrigin;
         end
      end
   end

   // Event report to the core
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eventTaken      <= 1'b0;
         eventActionOut  <= DECU_ACT_NONE;
         breakBeforeMake <= 1'b0;
      end else begin
         eventTaken      <= anyFire && winAct != DECU_ACT_NONE;
         eventActionOut  <= anyFire ? winAct : DECU_ACT_NONE;
         // Data-involving combos cannot stop before commit
         breakBeforeMake <= anyFire && winSpec[`DECU_PCB_BIT] && !winIsTrig;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Specifier registers, one loop over all five
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : gSpec
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               spec_reg[gi] <= `DECU_ZERO32;
            end else if (wrEn && ((gi == 0 && hitPin) || (gi == 1 && hitGuard)
                         || (gi == 2 && hitSw) || (gi == 3 && hitT0)
                         || (gi == 4 && hitT1))) begin
               spec_reg[gi] <= pwdata & ((gi >= 3) ? `DECU_TRIG_MASK
                                                  : `DECU_SPEC_MASK);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Software breakpoint request control
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqPrio_reg   <= 8'h00;
         irqTarget_reg <= 2'b00;
         irqEnable_reg <= 1'b0;
      end else if (wrEn && hitIrq) begin
         irqPrio_reg   <= pwdata[`DECU_PRIO_HI:0];
         irqTarget_reg <= pwdata[`DECU_TGT_HI:`DECU_TGT_LO];
         irqEnable_reg <= pwdata[`DECU_EN_BIT];
      end
   end

   // Hardware set beats software clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqPend_reg <= 1'b0;
      end else if (anyFire && winAct == DECU_ACT_SWBK) begin
         irqPend_reg <= 1'b1;
      end else if (wrEn && hitIrq
                   && (pwdata[`DECU_SET_BIT] != pwdata[`DECU_CLR_BIT])) begin
         irqPend_reg <= pwdata[`DECU_SET_BIT];
      end
   end

   // Priority zero never serviced; reserved target goes nowhere
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqRequest     <= 1'b0;
         irqPriorityOut <= 8'h00;
         irqToCoproc    <= 1'b0;
      end else begin
         irqRequest     <= irqPend_reg && irqEnable_reg && (irqPrio_reg != 8'h00)
                           && !irqTarget_reg[1];
         irqPriorityOut <= irqPrio_reg;
         irqToCoproc    <= irqTarget_reg[0];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         haltOut <= 1'b0;
      end else begin
         haltOut <= halt_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB read path; mask and strobe bits always read zero
   always_comb begin
      rdData_next = `DECU_ZERO32;
      if (hitState) begin
         rdData_next[`DECU_ON_BIT]               = dbgOn_reg;
         rdData_next[`DECU_HALT_BIT]             = halt_reg;
         rdData_next[`DECU_SNOW_BIT]             = suspendOut;
         rdData_next[`DECU_SPRI_BIT]             = suspPrior_reg;
         rdData_next[`DECU_ORG_HI:`DECU_ORG_LO]  = origin_reg;
      end else if (hitPin) begin
         rdData_next = spec_reg[0];
      end else if (hitGuard) begin
         rdData_next = spec_reg[1];
      end else if (hitSw) begin
         rdData_next = spec_reg[2];
      end else if (hitT0) begin
         rdData_next = spec_reg[3];
      end else if (hitT1) begin
         rdData_next = spec_reg[4];
      end else if (hitIrq) begin
         rdData_next[`DECU_PRIO_HI:0]            = irqPrio_reg;
         rdData_next[`DECU_TGT_HI:`DECU_TGT_LO]  = irqTarget_reg;
         rdData_next[`DECU_EN_BIT]               = irqEnable_reg;
         rdData_next[`DECU_PEND_BIT] = irqPend_reg;
      end
   end

   // No wait state: data captured in setup, ready in first access cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata  <= `DECU_ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !(hitState || hitPin || hitGuard || hitSw
                    || hitT0 || hitT1 || hitIrq);
         if (rdEn) begin
            prdata <= rdData_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   halt_write_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      (wrEn && hitState && pwdata[2:1] == 2'b10 && !(anyFire && winAct == DECU_ACT_HALT))
      |=> !halt_reg)
      else $error("halt not cleared by 10 write");
   halt_needs_on_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(halt_reg) |-> $past(dbgOn_reg) || $past(anyFire))
      else $error("halt set without debug enabled");
   break_pulse_one_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winAct == DECU_ACT_HALT) |=> breakOutPin)
      else $error("break pin not pulsed on halt entry");
   reserved_action_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winSpec[2:0] > 3'b100) |=> !eventTaken && !breakOutPin)
      else $error("reserved action acted");
   stall_signal_now_follows_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winAct != DECU_ACT_NONE) |=> suspendOut == $past(winSpec[5]))
      else $error("suspend not taken from specifier");
   trig_after_make_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winIsTrig) |=> !breakBeforeMake)
      else $error("trigger event broke before make");
   both_strobes_a: assert property (@(posedge clk) disable iff (!resetn)
      (wrEn && hitIrq && pwdata[15] && pwdata[14] && !anyFire) |=> $stable(irqPend_reg))
      else $error("pending changed with both strobes");
   origin_record_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winAct == DECU_ACT_TRAP) |=> origin_reg == $past(winOrigin))
      else $error("origin not recorded on trap");
   swbk_pend_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winAct == DECU_ACT_SWBK) |=> irqPend_reg ##1 (irqRequest
      || !irqEnable_reg || irqPrio_reg == 8'h00 || irqTarget_reg[1]))
      else $error("software breakpoint request missing");
   prio_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      irqRequest |-> $past(irqPrio_reg) != 8'h00)
      else $error("request with priority zero");

   // Software side of the halt, request and suspend controls; pin action report
   halt_off_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      (wrEn && hitState && pwdata[`DECU_HMASK_BIT] && pwdata[`DECU_HALT_BIT] && !dbgOn_reg
       && !(anyFire && winAct == DECU_ACT_HALT)) |=> $stable(halt_reg))
      else $error("halt set with debug disabled");
   clear_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
      (wrEn && hitIrq && pwdata[`DECU_CLR_BIT] && !pwdata[`DECU_SET_BIT]
       && !(anyFire && winAct == DECU_ACT_SWBK)) |=> !irqPend_reg)
      else $error("pending not cleared by strobe");
   irq_needs_en_a: assert property (@(posedge clk) disable iff (!resetn)
      irqRequest |-> $past(irqEnable_reg) && !$past(irqTarget_reg[1]))
      else $error("request while disabled or reserved target");
   pin_action_a: assert property (@(posedge clk) disable iff (!resetn)
      (anyFire && winAct == DECU_ACT_PIN) |=> breakOutPin && eventActionOut == DECU_ACT_PIN)
      else $error("pin action not reported");
   stall_signal_now_prior_a: assert property (@(posedge clk) disable iff (!resetn)
      (wrEn && hitState) |=> suspPrior_reg == $past(suspendOut))
      else $error("previous suspend not kept");

   halt_cover_c: cover property (@(posedge clk) disable iff (!resetn) $rose(halt_reg));
   trap_cover_c: cover property (@(posedge clk) disable iff (!resetn)
      anyFire && winAct == DECU_ACT_TRAP);
   irq_cover_c:  cover property (@(posedge clk) disable iff (!resetn) $rose(irqRequest));
   multi_cover_c: cover property (@(posedge clk) disable iff (!resetn) fire[0] && fire[3]);
   swbk_cover_c: cover property (@(posedge clk) disable iff (!resetn)
      anyFire && winAct == DECU_ACT_SWBK);

endmodule
`default_nettype wire

// >>> tb/decu_event_src.sv
`timescale 1ns/1ns
`default_nettype none

module decu_event_src (
   // Clock and core state
   input  wire logic       clk,
   input  wire logic       haltIn,
   // Event sources
   output var  logic       breakInEvent,
   output var  logic       guardAccessEvent,
   output var  logic       swDebugEvent,
   output var  logic [3:0] trig0Combo,
   output var  logic [3:0] trig1Combo
);
   initial begin
      breakInEvent = 1'b0;
      guardAccessEvent = 1'b0;
      swDebugEvent = 1'b0;
      trig0Combo = 4'h0;
      trig1Combo = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One-cycle pulses launched after an edge, so each is seen exactly once
   task automatic fire(input logic [2:0] s, input logic [3:0] c0, input logic [3:0] c1);
      @(posedge clk);
      breakInEvent <= s[0];
      guardAccessEvent <= s[1];
      swDebugEvent <= s[2] & ~haltIn; // A halted core issues no software debug event
      trig0Combo <= c0;
      trig1Combo <= c1;
      @(posedge clk);
      breakInEvent <= 1'b0;
      guardAccessEvent <= 1'b0;
      swDebugEvent <= 1'b0;
      trig0Combo <= 4'h0;
      trig1Combo <= 4'h0;
   endtask
endmodule

`default_nettype wire

// >>> tb/tb_debug_event_control_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "decu_defs.svh"

module tb_debug_event_control_unit;
   import decu_pkg::*;
   logic clk, resetn, psel, penable, pwrite, strap;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic pready, pslverr, erv, brk, halt, stall_signal_now, pre_commit_break, taken, irq, toCop;
   logic bi, ga, sw;
   logic [3:0] c0, c1;
   logic [2:0] act;
   logic [7:0] prio;
   int err_total, num_checks;

   decu_event_ctrl uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dbgEnableStrap(strap), .breakInEvent(bi), .guardAccessEvent(ga),
      .swDebugEvent(sw), .trig0Combo(c0), .trig1Combo(c1), .breakOutPin(brk),
      .haltOut(halt), .suspendOut(stall_signal_now), .breakBeforeMake(pre_commit_break), .eventTaken(taken),
      .eventActionOut(act), .irqRequest(irq), .irqPriorityOut(prio), .irqToCoproc(toCop));
   decu_event_src evSrc (.clk(clk), .haltIn(halt), .breakInEvent(bi),
      .guardAccessEvent(ga), .swDebugEvent(sw), .trig0Combo(c0), .trig1Combo(c1));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rst(input logic s);
      resetn <= 1'b0;
      strap <= s;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask

   // Request held until pready is sampled high at a rising edge; the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk(n, e, rdv);
   endtask

   // Fires sources and judges the one-cycle outputs in the cycle they stand
   task automatic ev(input logic [2:0] s, input logic [3:0] t0, input logic [3:0] t1,
                     input logic eb, input logic ebb, input logic [2:0] ea);
      evSrc.fire(s, t0, t1);
      #1;
      chk("breakOut", {31'h0, eb}, {31'h0, brk});
      chk("bbm", {31'h0, ebb}, {31'h0, pre_commit_break});
      chk("action", {29'h0, ea}, {29'h0, act});
      chk("taken", {31'h0, ea != 3'h0}, {31'h0, taken});
      @(posedge clk);
      #1;
      chk("breakEnd", 32'h00000000, {31'h0, brk});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rdc("state", `DECU_OFS_STATE, 32'h00000001);
      wr(`DECU_OFS_PIN, 32'hFFFFFFFF);
      rdc("pin", `DECU_OFS_PIN, 32'h0000002F);
      wr(`DECU_OFS_GUARD, 32'hFFFFFFFF);
      rdc("guard", `DECU_OFS_GUARD, 32'h0000002F);
      wr(`DECU_OFS_SWB, 32'hFFFFFFFF);
      rdc("swb", `DECU_OFS_SWB, 32'h0000002F);
      rdc("trig1", `DECU_OFS_TRIG1, 32'h00000000);
      wr(`DECU_OFS_TRIG0, 32'hFFFFFFFF);
      rdc("trig0", `DECU_OFS_TRIG0, 32'h00000F2F);
      wr(`DECU_OFS_IRQ, 32'hFFFFFFFF);
      rdc("irqBoth", `DECU_OFS_IRQ, 32'h00001CFF);
      rdc("hole", 12'h004, 32'h00000000);
      chk("slverr", 32'h00000001, {31'h0, erv});
      wr(`DECU_OFS_IRQ, 32'h00000000);
   endtask

   task automatic t_halt();
      wr(`DECU_OFS_STATE, 32'h00000002);
      rdc("halt01", `DECU_OFS_STATE, 32'h00000001);
      wr(`DECU_OFS_STATE, 32'h00000006);
      rdc("halt11", `DECU_OFS_STATE, 32'h00000003);
      chk("haltOut", 32'h00000001, {31'h0, halt});
      wr(`DECU_OFS_STATE, 32'h00000000);
      rdc("halt00", `DECU_OFS_STATE, 32'h00000003);
      wr(`DECU_OFS_STATE, 32'h00000004);
      rdc("halt10", `DECU_OFS_STATE, 32'h00000001);
      chk("haltOff", 32'h00000000, {31'h0, halt});
   endtask

   task automatic t_actions();
      for (int c = 0; c < 8; c++) begin
         wr(`DECU_OFS_PIN, 32'(c));
         ev(3'b001, 4'h0, 4'h0, c >= 1 && c <= 3, 1'b0, c < 5 ? 3'(c) : 3'h0);
         rdc("actHalt", `DECU_OFS_STATE, c == 2 ? 32'h00000003 : 32'h00000001);
         rdc("actPend", `DECU_OFS_IRQ, c == 4 ? 32'h00002000 : 32'h00000000);
         wr(`DECU_OFS_STATE, 32'h00000004);
         wr(`DECU_OFS_IRQ, 32'h00004000);
      end
   endtask

   task automatic t_origin();
      logic [2:0] s[5] = '{3'b010, 3'b100, 3'b000, 3'b000, 3'b001};
      logic [4:0] o[5] = '{5'h01, 5'h02, 5'h10, 5'h11, 5'h00};
      wr(`DECU_OFS_PIN, 32'h00000003);
      wr(`DECU_OFS_GUARD, 32'h00000003);
      wr(`DECU_OFS_SWB, 32'h00000003);
      wr(`DECU_OFS_TRIG0, 32'h00000103);
      wr(`DECU_OFS_TRIG1, 32'h00000103);
      for (int i = 0; i < 5; i++) begin
         ev(s[i], {3'h0, i == 2}, {3'h0, i == 3}, 1'b1, 1'b0, 3'h3);
         rdc("origin", `DECU_OFS_STATE, {19'h0, o[i], 8'h01});
      end
      wr(`DECU_OFS_GUARD, 32'h00000002);
      wr(`DECU_OFS_TRIG0, 32'h00000403);
      ev(3'b011, 4'b0100, 4'h0, 1'b1, 1'b0, 3'h3);
      rdc("winner", `DECU_OFS_STATE, 32'h00000001);
   endtask

   task automatic t_trig();
      wr(`DECU_OFS_TRIG0, 32'h00000401);
      ev(3'b000, 4'b0100, 4'h0, 1'b1, 1'b0, 3'h1);
      ev(3'b000, 4'b1011, 4'h0, 1'b0, 1'b0, 3'h0);
      wr(`DECU_OFS_TRIG0, 32'h00000409);
      ev(3'b000, 4'b0100, 4'h0, 1'b1, 1'b0, 3'h1);
      wr(`DECU_OFS_PIN, 32'h00000009);
      ev(3'b001, 4'h0, 4'h0, 1'b1, 1'b1, 3'h1);
      wr(`DECU_OFS_PIN, 32'h00000021);
      ev(3'b001, 4'h0, 4'h0, 1'b1, 1'b0, 3'h1);
      chk("suspOn", 32'h00000001, {31'h0, stall_signal_now});
      rdc("stall_signal_now", `DECU_OFS_STATE, 32'h00000011);
      wr(`DECU_OFS_PIN, 32'h00000001);
      ev(3'b001, 4'h0, 4'h0, 1'b1, 1'b0, 3'h1);
      chk("suspOff", 32'h00000000, {31'h0, stall_signal_now});
      rdc("prior", `DECU_OFS_STATE, 32'h00000041);
   endtask

   task automatic t_irq();
      wr(`DECU_OFS_IRQ, 32'h00009405);
      rdc("irqSet", `DECU_OFS_IRQ, 32'h00003405);
      chk("irqReq", 32'h00000001, {31'h0, irq});
      chk("irqPrio", 32'h00000005, {24'h0, prio});
      chk("irqCop", 32'h00000001, {31'h0, toCop});
      wr(`DECU_OFS_IRQ, 32'h00001000);
      rdc("prio0", `DECU_OFS_IRQ, 32'h00003000);
      chk("irqNone", 32'h00000000, {31'h0, irq});
      wr(`DECU_OFS_IRQ, 32'h00000005);
      rdc("irqDis", `DECU_OFS_IRQ, 32'h00002005);
      chk("irqOff", 32'h00000000, {31'h0, irq});
      wr(`DECU_OFS_IRQ, 32'h0000C005);
      rdc("both", `DECU_OFS_IRQ, 32'h00002005);
      wr(`DECU_OFS_IRQ, 32'h00004005);
      rdc("irqClr", `DECU_OFS_IRQ, 32'h00000005);
   endtask

   task automatic t_off();
      rst(1'b0);
      rdc("stateOff", `DECU_OFS_STATE, 32'h00000000);
      wr(`DECU_OFS_STATE, 32'h00000006);
      rdc("noHalt", `DECU_OFS_STATE, 32'h00000000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      num_checks = 0;
      resetn = 1'b0;
      strap = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      rst(1'b1);
      t_regs();
      t_halt();
      t_actions();
      t_origin();
      t_trig();
      t_irq();
      t_off();
      conclude();
   end

   // Whole run is about four hundred cycles; this bound only catches a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule

`default_nettype wire
